// file: include/apt_pkg.sv
// Shared constants and types for the waveform playback trigger controller
package apt_pkg;
  // Trigger styles
  typedef enum logic [2:0] {
    APT_STY_CONT,
    APT_STY_IGNORE,
    APT_STY_BUFFER,
    APT_STY_REALTIME,
    APT_STY_SEGMENT,
    APT_STY_GATE
  } apt_style_e;

  // Trigger sources
  typedef enum logic [1:0] {
    APT_SRC_KEY,
    APT_SRC_EXT,
    APT_SRC_BUS,
    APT_SRC_INT
  } apt_source_e;

  // Controller states
  typedef enum logic {
    APT_IDLE,
    APT_PLAY
  } apt_state_e;

  // Reset values
  localparam logic APT_RST_PLAYING = 1'b0;
  localparam logic APT_RST_PENDING = 1'b0;
  localparam logic APT_RST_SYNC = 1'b0;

  // Default widths
  localparam int APT_SEG_LEN_W = 16;
  localparam int APT_SEG_IDX_W = 4;
endpackage

// file: verilog/apt_trig_cond.sv
// Trigger source selection with external input synchroniser and edge finder
module apt_trig_cond
  import apt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire apt_source_e src_sel,
  input wire logic ext_polarity,
  input wire logic ext_trig,
  input wire logic key_trig,
  input wire logic bus_trig,
  input wire logic int_trig,
  output logic trig_pulse,
  output logic gate_level
);
  logic sync_a;
  logic sync_b;
  logic lvl_d;
  logic ext_lvl;
  logic ext_edge;
  logic next_trig;

  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= APT_RST_SYNC;
      sync_b <= APT_RST_SYNC;
    end else begin
      sync_a <= ext_trig;
      sync_b <= sync_a;
    end
  end

  // Polarity folds a negative gate into an active-high level
  assign ext_lvl = ext_polarity ? sync_b : ~sync_b;
  // Edge found on the raw pin level, so a polarity change or reset never fakes a trigger
  assign ext_edge = ext_polarity ? (sync_b & ~lvl_d) : (~sync_b & lvl_d);

  // One source at a time; the others are dropped
  always_comb begin
    next_trig = 1'b0;
    unique case (src_sel)
      APT_SRC_KEY: next_trig = key_trig;
      APT_SRC_EXT: next_trig = ext_edge;
      APT_SRC_BUS: next_trig = bus_trig;
      APT_SRC_INT: next_trig = int_trig;
    endcase
  end

  // Registered outputs keep the trigger pulse glitch free
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_d <= APT_RST_SYNC;
      trig_pulse <= 1'b0;
      gate_level <= 1'b0;
    end else begin
      lvl_d <= sync_b;
      trig_pulse <= next_trig;
      gate_level <= ext_lvl;
    end
  end

  a_source_pick: assert property (@(posedge mclk) disable iff (!rst_b)
    src_sel == APT_SRC_BUS && bus_trig |=> trig_pulse)
    else $error("bus trigger not passed on");
  a_ext_edge_find: assert property (@(posedge mclk) disable iff (!rst_b)
    src_sel == APT_SRC_EXT && sync_b == ext_polarity && lvl_d != ext_polarity |=> trig_pulse)
    else $error("external edge not turned into a trigger");
  a_ext_no_level: assert property (@(posedge mclk) disable iff (!rst_b)
    src_sel == APT_SRC_EXT && sync_b == lvl_d |=> !trig_pulse)
    else $error("steady external level gave a trigger");
endmodule

// file: verilog/apt_play_ctrl.sv
// Playback trigger controller: starts, restarts, queues, advances and stops segments
module apt_play_ctrl
  import apt_pkg::*;
#(
  parameter int SEG_LEN_W = APT_SEG_LEN_W,
  parameter int SEG_IDX_W = APT_SEG_IDX_W
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic arb_on,
  input wire apt_style_e style,
  input wire apt_source_e src_sel,
  input wire logic ext_polarity,
  input wire logic ext_trig,
  input wire logic key_trig,
  input wire logic bus_trig,
  input wire logic int_trig,
  input wire logic [SEG_IDX_W-1:0] seg_count,
  input wire logic [SEG_LEN_W-1:0] seg_len,
  output logic playing,
  output logic [SEG_LEN_W-1:0] sample_addr,
  output logic [SEG_IDX_W-1:0] seg_idx,
  output logic buffered,
  output logic seg_start,
  output logic seg_done
);
  if (SEG_LEN_W < 2 || SEG_LEN_W > 32) begin : g_bad_len
    $error("SEG_LEN_W out of range");
  end
  if (SEG_IDX_W < 1 || SEG_IDX_W > 16) begin : g_bad_idx
    $error("SEG_IDX_W out of range");
  end

  logic trig;
  logic gate;
  logic last;
  logic [SEG_IDX_W-1:0] seg_next;
  logic next_playing;
  logic [SEG_LEN_W-1:0] next_addr;
  logic [SEG_IDX_W-1:0] next_idx;
  logic next_pend;
  logic next_start;
  logic next_done;

  // Wraps to the first segment after the last one in the sequence
  function automatic logic [SEG_IDX_W-1:0] next_seg(input logic [SEG_IDX_W-1:0] idx,
                                                    input logic [SEG_IDX_W-1:0] cnt);
    logic [SEG_IDX_W-1:0] inc;
    inc = idx + 1'b1;
    if (inc >= cnt || inc == '0) begin
      next_seg = '0;
    end else begin
      next_seg = inc;
    end
  endfunction

  apt_trig_cond u_trig (
    .mclk(mclk),
    .rst_b(rst_b),
    .src_sel(src_sel),
    .ext_polarity(ext_polarity),
    .ext_trig(ext_trig),
    .key_trig(key_trig),
    .bus_trig(bus_trig),
    .int_trig(int_trig),
    .trig_pulse(trig),
    .gate_level(gate)
  );

  // A zero length is served as a one-sample segment
  assign last = (seg_len == '0) || (sample_addr == seg_len - 1'b1);
  assign seg_next = next_seg(seg_idx, seg_count);

  // Next-state decision for all trigger styles
  always_comb begin
    next_playing = playing;
    next_addr = sample_addr;
    next_idx = seg_idx;
    next_pend = buffered;
    next_start = 1'b0;
    next_done = 1'b0;
    if (!arb_on) begin
      next_playing = APT_RST_PLAYING;
      next_addr = '0;
      next_idx = '0;
      next_pend = APT_RST_PENDING;
    end else if (style == APT_STY_GATE) begin
      next_pend = 1'b0;
      if (gate) begin
        next_playing = 1'b1;
        if (!playing) begin
          next_start = 1'b1;
        end else if (last) begin
          next_addr = '0;
          next_idx = seg_next;
          next_done = 1'b1;
          next_start = 1'b1;
        end else begin
          next_addr = sample_addr + 1'b1;
        end
      end else begin
        // Pause keeps the position so the gate resumes where it stopped
        next_playing = 1'b0;
      end
    end else if (trig && (!playing || style == APT_STY_CONT || style == APT_STY_REALTIME)) begin
      next_playing = 1'b1;
      next_addr = '0;
      next_pend = 1'b0;
      next_start = 1'b1;
    end else if (playing) begin
      if (last) begin
        next_done = 1'b1;
        next_addr = '0;
        unique case (style)
          APT_STY_CONT: next_start = 1'b1;
          APT_STY_BUFFER: begin
            // A trigger on the last sample counts as the remembered one
            if (buffered || trig) begin
              next_pend = 1'b0;
              next_start = 1'b1;
            end else begin
              next_playing = 1'b0;
            end
          end
          APT_STY_SEGMENT: begin
            next_playing = 1'b0;
            next_idx = seg_next;
          end
          default: next_playing = 1'b0;
        endcase
      end else begin
        next_addr = sample_addr + 1'b1;
        if (style == APT_STY_BUFFER && trig) begin
          next_pend = 1'b1;
        end
      end
    end else begin
      next_addr = '0;
      next_pend = 1'b0;
    end
  end

  // Playback state and position
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      playing <= APT_RST_PLAYING;
      sample_addr <= '0;
      seg_idx <= '0;
    end else begin
      playing <= next_playing;
      sample_addr <= next_addr;
      seg_idx <= next_idx;
    end
  end

  // Remembered trigger, only one deep
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      buffered <= APT_RST_PENDING;
    end else begin
      buffered <= next_pend;
    end
  end

  // Segment event pulses for the datapath
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      seg_start <= 1'b0;
      seg_done <= 1'b0;
    end else begin
      seg_start <= next_start;
      seg_done <= next_done;
    end
  end

  sequence s_buf_mid;
    style == APT_STY_BUFFER && arb_on && playing && trig && !last;
  endsequence
  sequence s_buf_end;
    style == APT_STY_BUFFER && arb_on && playing && last && buffered;
  endsequence
  sequence s_gate_low;
    style == APT_STY_GATE && arb_on && !gate;
  endsequence
  sequence s_gate_high;
    style == APT_STY_GATE && arb_on && gate;
  endsequence

  a_cont_restart: assert property (@(posedge mclk) disable iff (!rst_b)
    style == APT_STY_CONT && arb_on && trig |=> playing && sample_addr == '0)
    else $error("continuous trigger did not restart the segment");
  // Continuous style loops, so the datapath sees a fresh start at each segment end
  a_cont_loop: assert property (@(posedge mclk) disable iff (!rst_b)
    style == APT_STY_CONT && arb_on && playing && last && !trig
    |=> playing && sample_addr == '0 && seg_start)
    else $error("continuous segment did not loop");
  a_ignore_drop: assert property (@(posedge mclk) disable iff (!rst_b)
    style == APT_STY_IGNORE && arb_on && playing && trig && !last
    |=> playing && sample_addr == $past(sample_addr) + 1'b1)
    else $error("repeated trigger disturbed single playback");
  a_buffer_keep: assert property (@(posedge mclk) disable iff (!rst_b)
    s_buf_mid |=> buffered)
    else $error("trigger during playback not remembered");
  a_buffer_replay: assert property (@(posedge mclk) disable iff (!rst_b)
    s_buf_end |=> (playing && sample_addr == '0 && !buffered) ##1 (sample_addr == 1 || last))
    else $error("remembered trigger did not start a new playback");
  a_real_abort: assert property (@(posedge mclk) disable iff (!rst_b)
    style == APT_STY_REALTIME && arb_on && playing && trig |=> playing && sample_addr == '0)
    else $error("realtime trigger did not restart from first sample");
  a_seg_advance: assert property (@(posedge mclk) disable iff (!rst_b)
    style == APT_STY_SEGMENT && arb_on && playing && last && !trig
    |=> !playing && seg_idx == $past(seg_next))
    else $error("segment style did not move to next segment");
  // A trigger while a segment plays must neither restart it nor skip a segment
  a_seg_one_shot: assert property (@(posedge mclk) disable iff (!rst_b)
    style == APT_STY_SEGMENT && arb_on && playing && trig && !last
    |=> playing && sample_addr == $past(sample_addr) + 1'b1 && $stable(seg_idx))
    else $error("trigger during segment play disturbed it");
  a_gate_run: assert property (@(posedge mclk) disable iff (!rst_b)
    style == APT_STY_GATE && arb_on && gate && playing && !last
    |=> playing && sample_addr == $past(sample_addr) + 1'b1)
    else $error("gate high did not keep playing");
  a_gate_halt: assert property (@(posedge mclk) disable iff (!rst_b)
    s_gate_low ##1 s_gate_low |=> !playing && $stable(sample_addr))
    else $error("gate low did not halt playback");
  // Pause rather than rewind: the gate picks up at the held sample and segment
  a_gate_resume: assert property (@(posedge mclk) disable iff (!rst_b)
    s_gate_low ##1 s_gate_high |=> playing && $stable(sample_addr) && $stable(seg_idx))
    else $error("gate high did not resume in place");
endmodule

// file: bench/apt_ext_src.sv
// Far-side model of the external trigger source that drives the trigger pin
module apt_ext_src (
  input wire logic mclk,
  output logic ext_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ext_trig = 1'b0;
  // Active pulse of w cycles, then back to the idle level of that polarity
  task automatic fire(input logic pol, input int w);
    @(posedge mclk) ext_trig <= pol;
    repeat (w) @(posedge mclk);
    ext_trig <= ~pol;
  endtask
  // Gate level held until the next call
  task automatic gate(input logic v);
    @(posedge mclk) ext_trig <= v;
  endtask
endmodule

// file: bench/apt_play_ctrl_tb.sv
// Self-checking bench for the playback trigger controller
module apt_play_ctrl_tb;
  import apt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LEN = 4;
  logic mclk, rst_b, arb_on, ext_polarity, ext_trig, key_trig, bus_trig, int_trig;
  apt_style_e style;
  apt_source_e src_sel;
  logic [APT_SEG_IDX_W-1:0] seg_count, seg_idx;
  logic [APT_SEG_LEN_W-1:0] seg_len, sample_addr;
  logic playing, buffered, seg_start, seg_done;
  int fail_count, cmp_count;
  apt_play_ctrl dut (.mclk(mclk), .rst_b(rst_b), .arb_on(arb_on), .style(style),
    .src_sel(src_sel), .ext_polarity(ext_polarity), .ext_trig(ext_trig),
    .key_trig(key_trig), .bus_trig(bus_trig), .int_trig(int_trig), .seg_count(seg_count),
    .seg_len(seg_len), .playing(playing), .sample_addr(sample_addr), .seg_idx(seg_idx),
    .buffered(buffered), .seg_start(seg_start), .seg_done(seg_done));
  apt_ext_src src (.mclk(mclk), .ext_trig(ext_trig));
  // Clock at 25 MHz
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Sample 1 ns after the edge so the edge's updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic setup(input apt_style_e s, input apt_source_e q);
    @(posedge mclk) arb_on <= 1'b0;
    style <= s;
    src_sel <= q;
    @(posedge mclk) arb_on <= 1'b1;
  endtask
  // One-cycle trigger pulse; returns at the edge that samples it
  task automatic pulse(input apt_source_e q);
    @(posedge mclk);
    key_trig <= (q == APT_SRC_KEY);
    bus_trig <= (q == APT_SRC_BUS);
    int_trig <= (q == APT_SRC_INT);
    @(posedge mclk);
    {key_trig, bus_trig, int_trig} <= 3'h0;
  endtask
  // Start is visible after the edge that follows the sampling edge
  task automatic start(input apt_source_e q, input string m);
    pulse(q);
    cyc(1);
    chk(playing === 1'b1 && sample_addr === '0 && seg_start === 1'b1, m);
  endtask
  task automatic wait_play(input logic v, input int lim, input string m);
    int i;
    #1;
    for (i = 0; i < lim && playing !== v; i++) cyc(1);
    chk(playing === v, m);
  endtask
  // Restart styles: the continuous one loops, the realtime one stops at the end
  task automatic t_restart(input apt_style_e s, input apt_source_e q);
    setup(s, q);
    start(q, "first start");
    start(q, "restart mid segment");
    cyc(LEN);
    chk(playing === (s == APT_STY_CONT) && sample_addr === '0, "segment end");
  endtask
  // A trigger during playback is dropped
  task automatic t_ignore();
    setup(APT_STY_IGNORE, APT_SRC_BUS);
    start(APT_SRC_BUS, "ignore start");
    pulse(APT_SRC_BUS);
    cyc(2);
    chk(playing === 1'b0 && seg_done === 1'b1, "ignore end");
    cyc(3);
    chk(playing === 1'b0, "ignored trigger replayed");
  endtask
  // A trigger during playback is held and replays at the end
  task automatic t_buffer();
    setup(APT_STY_BUFFER, APT_SRC_BUS);
    start(APT_SRC_BUS, "buffer start");
    pulse(APT_SRC_BUS);
    cyc(1);
    chk(buffered === 1'b1 && playing === 1'b1, "trigger not held");
    cyc(1);
    chk(playing === 1'b1 && sample_addr === '0 && buffered === 1'b0, "no replay");
  endtask
  // Each trigger plays the next segment, wrapping at the count; a mid-play trigger is dropped
  task automatic t_segment();
    int k;
    setup(APT_STY_SEGMENT, APT_SRC_KEY);
    for (k = 0; k < 4; k++) begin
      start(APT_SRC_KEY, "segment start");
      chk(seg_idx === 4'(k % 3), "segment index");
      if (k == 1) begin
        pulse(APT_SRC_KEY);
        cyc(2);
      end else begin
        cyc(LEN);
      end
      chk(playing === 1'b0, "segment not stopped");
    end
  endtask
  // External edge of either polarity starts one playback
  task automatic t_ext(input logic pol);
    setup(APT_STY_IGNORE, APT_SRC_EXT);
    ext_polarity <= pol;
    src.gate(~pol);
    cyc(6);
    chk(playing === 1'b0, "idle level started play");
    src.fire(pol, 2);
    wait_play(1'b1, 6, "external edge missed");
    wait_play(1'b0, LEN + 2, "external play no end");
    cyc(6);
    chk(playing === 1'b0, "trailing edge started play");
  endtask
  // Gate high plays segments in turn, low halts and holds, high again resumes in place
  task automatic t_gate();
    logic [APT_SEG_LEN_W-1:0] held_addr;
    logic [APT_SEG_IDX_W-1:0] held_idx;
    setup(APT_STY_GATE, APT_SRC_EXT);
    ext_polarity <= 1'b1;
    src.gate(1'b1);
    wait_play(1'b1, 8, "gate high no play");
    cyc(LEN + 2);
    chk(playing === 1'b1 && seg_idx === 4'h1, "gate no advance");
    src.gate(1'b0);
    wait_play(1'b0, 8, "gate low still plays");
    held_addr = sample_addr;
    held_idx = seg_idx;
    cyc(4);
    chk(playing === 1'b0 && sample_addr === held_addr, "gate low resumed");
    src.gate(1'b1);
    wait_play(1'b1, 8, "gate high no resume");
    chk(sample_addr === held_addr && seg_idx === held_idx, "gate resume moved");
  endtask
  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well beyond the fewer than two hundred cycles the tests take
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    {rst_b, arb_on, ext_polarity, key_trig, bus_trig, int_trig} = 6'h0;
    style = APT_STY_CONT;
    src_sel = APT_SRC_KEY;
    seg_count = 4'h3;
    seg_len = 16'(LEN);
    fail_count = 0;
    cmp_count = 0;
    cyc(4);
    chk(playing === 1'b0 && seg_start === 1'b0 && sample_addr === '0, "reset values");
    @(posedge mclk) rst_b <= 1'b1;
    t_restart(APT_STY_CONT, APT_SRC_KEY);
    t_restart(APT_STY_REALTIME, APT_SRC_INT);
    t_ignore();
    t_buffer();
    t_segment();
    t_ext(1'b1);
    t_ext(1'b0);
    t_gate();
    complete_run();
  end
endmodule
